/* File: logic/motl_limiter.sv */
// thermal overload limiter: apb registers, i2t accumulator, current clamp
// assumes measured current arrives in ma from logic on the same clock
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module motl_limiter #(
  parameter int CTRL_CYC = motl_pkg::CTRL_PERIOD_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [31:0] measured_current_i,
  output logic [31:0] imposed_current_limit_o,
  output logic limiter_active_o,
  output logic period_tick_o
);
  import motl_pkg::*;

  // software settings
  logic [31:0] submode;
  logic [31:0] max_motor_cur;
  logic [31:0] rated_cur;
  logic [31:0] peak_permille;
  logic [31:0] peak_duration;
  logic [31:0] next_submode;
  logic [31:0] next_max_motor_cur;
  logic [31:0] next_rated_cur;
  logic [31:0] next_peak_permille;
  logic [31:0] next_peak_duration;
  // derived state
  logic [31:0] peak_cur;
  logic [31:0] next_peak_cur;
  logic [63:0] threshold;
  logic [63:0] next_threshold;
  logic [63:0] accumulated_heat_value;
  logic [63:0] next_accumulated_heat_value;
  logic [31:0] imposed_current_limit;
  logic [31:0] next_imposed_current_limit;
  logic [31:0] period_cnt;
  logic [31:0] next_period_cnt;
  logic [31:0] sample;
  logic [31:0] next_sample;
  logic [31:0] prdata;
  logic [31:0] next_prdata;
  motl_state_t state;
  motl_state_t next_state;
  // shared multiplier operands and product
  logic [31:0] mul_a;
  logic [31:0] mul_b;
  logic [63:0] mul_p;
  logic [63:0] rated_sq;
  logic [63:0] excess_sq;
  logic [1:0] step;
  logic [1:0] next_step;
  // status and strobes
  logic active;
  logic wr_en;
  logic rd_setup;
  logic tick;

  motl_mult u_mult (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .a_i(mul_a),
    .b_i(mul_b),
    .p_o(mul_p)
  );

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign prdata_o = prdata;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_setup = psel_i && !penable_i && !pwrite_i;

  // writes land at the end of the access phase, reads prepared in setup
  always_comb begin
    next_submode = submode;
    next_max_motor_cur = max_motor_cur;
    next_rated_cur = rated_cur;
    next_peak_permille = peak_permille;
    next_peak_duration = peak_duration;
    next_prdata = prdata;
    if (wr_en) begin
      if (paddr_i == OFS_SUBMODE) begin
        next_submode = pwdata_i;
      end else if (paddr_i == OFS_MAX_MOTOR_CUR) begin
        next_max_motor_cur = pwdata_i;
      end else if (paddr_i == OFS_RATED_CUR) begin
        next_rated_cur = pwdata_i;
      end else if (paddr_i == OFS_PEAK_PERMILLE) begin
        next_peak_permille = pwdata_i;
      end else if (paddr_i == OFS_PEAK_DURATION) begin
        next_peak_duration = pwdata_i;
      end
    end
    if (rd_setup) begin
      if (paddr_i == OFS_SUBMODE) begin
        next_prdata = submode;
      end else if (paddr_i == OFS_MAX_MOTOR_CUR) begin
        next_prdata = max_motor_cur;
      end else if (paddr_i == OFS_RATED_CUR) begin
        next_prdata = rated_cur;
      end else if (paddr_i == OFS_PEAK_PERMILLE) begin
        next_prdata = peak_permille;
      end else if (paddr_i == OFS_PEAK_DURATION) begin
        next_prdata = peak_duration;
      end else if (paddr_i == OFS_THRESHOLD) begin
        next_prdata = threshold[31:0] | {32{|threshold[63:32]}};
      end else if (paddr_i == OFS_ACCUM) begin
        next_prdata = accumulated_heat_value[31:0] | {32{|accumulated_heat_value[63:32]}};
      end else if (paddr_i == OFS_LIMIT) begin
        next_prdata = imposed_current_limit;
      end else if (paddr_i == OFS_STATUS) begin
        next_prdata = {31'h0, active};
      end else begin
        next_prdata = 32'h0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      submode <= RST_SUBMODE;
      max_motor_cur <= RST_MAX_MOTOR_CUR;
      rated_cur <= RST_RATED_CUR;
      peak_permille <= RST_PEAK_PERMILLE;
      peak_duration <= RST_PEAK_DURATION;
      prdata <= 32'h0;
    end else begin
      submode <= next_submode;
      max_motor_cur <= next_max_motor_cur;
      rated_cur <= next_rated_cur;
      peak_permille <= next_peak_permille;
      peak_duration <= next_peak_duration;
      prdata <= next_prdata;
    end
  end

  // ------------------------------------------------------------
  // activation and peak current
  // ------------------------------------------------------------
  // peak current in ma, capped by the motor maximum
  always_comb begin
    logic [63:0] prod;
    logic [63:0] raw;
    prod = 64'(rated_cur) * 64'(peak_permille); // full width, no wrap
    raw = prod / 64'(PERMILLE_BASE);
    if (raw > 64'(max_motor_cur)) begin
      next_peak_cur = max_motor_cur;
    end else begin
      next_peak_cur = raw[31:0];
    end
  end

  assign active = submode[CLOSED_LOOP_BIT]
    && (peak_cur > rated_cur) && (peak_duration != 32'h0);
  assign limiter_active_o = active;

  // ------------------------------------------------------------
  // control period timer
  // ------------------------------------------------------------
  // free-running period counter, one-cycle tick at wrap
  always_comb begin
    next_period_cnt = period_cnt + 32'h1;
    tick = 1'b0;
    if (period_cnt >= 32'(CTRL_CYC - 1)) begin
      next_period_cnt = 32'h0;
      tick = 1'b1;
    end
  end
  assign period_tick_o = tick;

  // ------------------------------------------------------------
  // threshold and heat engine (shared multiplier)
  // ------------------------------------------------------------
  // rated current squared, shared by threshold and cooling
  assign rated_sq = 64'(rated_cur) * 64'(rated_cur);

  // peak^2 minus rated^2, floored at zero when peak is not above rated
  assign excess_sq = (mul_p > rated_sq) ? (mul_p - rated_sq) : 64'h0;

  // step 0: peak^2, step 1: (peak^2-rated^2)*dur, step 2: i^2 sample
  always_comb begin
    mul_a = peak_cur;
    mul_b = peak_cur;
    if (step == 2'd1) begin
      mul_a = excess_sq[31:0] | {32{|excess_sq[63:32]}};
      mul_b = peak_duration;
    end else if (step == 2'd2) begin
      mul_a = sample;
      mul_b = sample;
    end
  end

  // engine sequencing: sample at tick, three products, then heat update
  always_comb begin
    logic [63:0] incr;
    logic [63:0] cool;
    next_state = state;
    next_step = step;
    next_sample = sample;
    next_threshold = threshold;
    next_accumulated_heat_value = accumulated_heat_value;
    incr = 64'h0;
    cool = 64'h0;
    case (state)
      MOTL_IDLE: begin
        if (tick) begin
          next_sample = measured_current_i;
          next_step = 2'd0;
          next_state = MOTL_CALC;
        end
      end
      MOTL_CALC: begin
        next_step = step + 2'd1;
        if (step == 2'd2) begin
          // (peak^2-rated^2)*duration in ma^2 ms, scaled to a^2 ms
          next_threshold = mul_p / 64'(MA2_PER_A2);
          next_state = MOTL_DONE;
        end
      end
      MOTL_DONE: begin
        // add sample^2 over one period, remove rated^2 heat it sheds
        incr = mul_p / 64'(MA2_PER_A2);
        cool = rated_sq / 64'(MA2_PER_A2);
        if (!active) begin
          next_accumulated_heat_value = 64'h0;
        end else if (accumulated_heat_value + incr > cool) begin
          next_accumulated_heat_value = accumulated_heat_value + incr - cool;
        end else begin
          next_accumulated_heat_value = 64'h0;
        end
        next_state = MOTL_IDLE;
      end
      default: begin
        next_state = MOTL_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // imposed limit
  // ------------------------------------------------------------
  always_comb begin
    if (!active) begin
      next_imposed_current_limit = max_motor_cur;
    end else if (next_accumulated_heat_value >= next_threshold) begin
      next_imposed_current_limit = rated_cur;
    end else begin
      next_imposed_current_limit = peak_cur;
    end
  end
  assign imposed_current_limit_o = imposed_current_limit;

  // peak current register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      peak_cur <= 32'h0;
    end else begin
      peak_cur <= next_peak_cur;
    end
  end

  // control period counter register
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      period_cnt <= 32'h0;
    end else begin
      period_cnt <= next_period_cnt;
    end
  end

  // engine registers: sequencer, sample, threshold, heat value
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= MOTL_IDLE;
      step <= 2'd0;
      sample <= 32'h0;
      threshold <= 64'h0;
      accumulated_heat_value <= 64'h0;
    end else begin
      state <= next_state;
      step <= next_step;
      sample <= next_sample;
      threshold <= next_threshold;
      accumulated_heat_value <= next_accumulated_heat_value;
    end
  end

  // imposed limit register, output straight from the flop
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      imposed_current_limit <= 32'h0;
    end else begin
      imposed_current_limit <= next_imposed_current_limit;
    end
  end
endmodule : motl_limiter
`default_nettype wire

/* File: logic/motl_mult.sv */
// registered 32x32 multiplier used by the threshold and heat engine
// assumes the caller holds operands stable until the product is taken
`timescale 1ns/1ps
`default_nettype none
module motl_mult (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [31:0] a_i,
  input wire logic [31:0] b_i,
  output logic [63:0] p_o
);
  logic [63:0] next_p;

  // ------------------------------------------------------------
  // product register
  // ------------------------------------------------------------
  always_comb begin
    next_p = 64'(a_i) * 64'(b_i); // full 64-bit product
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p_o <= 64'h0;
    end else begin
      p_o <= next_p;
    end
  end
endmodule : motl_mult
`default_nettype wire

/* File: logic/motl_pkg.sv */
// package for the motor thermal overload limiter
// assumes a 50 MHz clock and an apb register bus with 32-bit data
// ------------------------------------------------------------
// Summary of operation
// - limiter runs only in closed-loop submode
// - rated current setting is in milliamperes
// - peak current in tenths of percent rated
// - peak duration is longest peak time, ms
// - inactive unless peak above rated, duration nonzero
// - integral limit derived from rated, peak, duration
// - peak allowed until limit, then clamp rated
// - peak never exceeds maximum motor current
// - threshold readable in ampere-squared milliseconds
// - accumulated value readable, compared against threshold
// - imposed current limit readable in milliamperes
// - status reads zero inactive, one active
// ------------------------------------------------------------
package motl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_SUBMODE = 8'h00;
  localparam logic [7:0] OFS_MAX_MOTOR_CUR = 8'h04;
  localparam logic [7:0] OFS_RATED_CUR = 8'h08;
  localparam logic [7:0] OFS_PEAK_PERMILLE = 8'h0C;
  localparam logic [7:0] OFS_PEAK_DURATION = 8'h10;
  localparam logic [7:0] OFS_THRESHOLD = 8'h14;
  localparam logic [7:0] OFS_ACCUM = 8'h18;
  localparam logic [7:0] OFS_LIMIT = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // field positions
  localparam int CLOSED_LOOP_BIT = 0;
  // reset values
  localparam logic [31:0] RST_SUBMODE = 32'h0000_0000;
  localparam logic [31:0] RST_MAX_MOTOR_CUR = 32'h0000_0000;
  localparam logic [31:0] RST_RATED_CUR = 32'h0000_0000;
  localparam logic [31:0] RST_PEAK_PERMILLE = 32'h0000_0000;
  localparam logic [31:0] RST_PEAK_DURATION = 32'h0000_0000;
  // scaling: permille base and ma^2 per a^2
  localparam logic [15:0] PERMILLE_BASE = 16'h03E8;
  localparam logic [31:0] MA2_PER_A2 = 32'h000F_4240;
  // timing: control period in us, cycles at 50 MHz
  localparam int CLK_PERIOD_NS = 20;
  localparam int CTRL_PERIOD_US = 1000;
  localparam int CTRL_PERIOD_CYC = (CTRL_PERIOD_US * 1000) / CLK_PERIOD_NS;
  // calculation engine states
  typedef enum logic [1:0] {MOTL_IDLE, MOTL_CALC, MOTL_DONE} motl_state_t;
endpackage : motl_pkg

/* File: verif/motl_limiter_assertions.sv */
// checker for the overload limiter ports
// assumes a bind from the bench top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module motl_limiter_assertions #(
  parameter int CTRL_CYC = 20
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [31:0] measured_current_i,
  input wire logic [31:0] imposed_current_limit_o,
  input wire logic limiter_active_o,
  input wire logic period_tick_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic wr_acc;
  logic [7:0] hist, next_hist;
  int cnt, next_cnt;
  logic seen, next_seen;
  // recent causes and tick spacing
  assign wr_acc = psel_i && penable_i && pwrite_i;
  always_comb begin
    next_hist = {hist[6:0], wr_acc | period_tick_o};
    next_cnt = period_tick_o ? 0 : cnt + 1;
    next_seen = seen | period_tick_o;
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hist <= 8'h00;
      cnt <= 0;
      seen <= 1'b0;
    end else begin
      hist <= next_hist;
      cnt <= next_cnt;
      seen <= next_seen;
    end
  end
  AST_READY:
    assert property (pready_o && !pslverr_o) else $error("bus answer not zero wait");
  AST_TICK_GAP:
    assert property (period_tick_o |=> !period_tick_o [*8]) else $error("tick too soon");
  AST_TICK_PERIOD:
    assert property (period_tick_o && seen |-> cnt == CTRL_CYC - 1) else $error("tick period wrong");
  AST_ACTIVE_CAUSE:
    assert property ($changed(limiter_active_o) |-> $past(wr_acc) || $past(wr_acc, 2)) else $error("status moved alone");
  AST_LIMIT_CAUSE:
    assert property ($changed(imposed_current_limit_o) |-> hist != 8'h00) else $error("limit moved alone");
  AST_PRDATA_CAUSE:
    assert property ($changed(prdata_o) |-> $past(psel_i && !penable_i && !pwrite_i)) else $error("read data moved");
  AST_UNMAPPED:
    assert property (psel_i && !penable_i && !pwrite_i && paddr_i > 8'h20 |=> prdata_o == 32'h0)
      else $error("unmapped read not zero");
  AST_ACTIVE_LIMIT:
    assert property (limiter_active_o && $past(limiter_active_o) |-> imposed_current_limit_o != 32'h0)
      else $error("active limit zero");
endmodule : motl_limiter_assertions
`default_nettype wire

/* File: verif/motl_motor_model.sv */
// far side model: current loop draws demand clamped to the limit
// assumes the limiter clock
`timescale 1ns/1ps
`default_nettype none
module motl_motor_model (
  input wire logic ref_clk_i,
  input wire logic [31:0] demand_i,
  input wire logic [31:0] limit_i,
  output logic [31:0] current_o
);
  logic [31:0] next_cur;
  // current settles one cycle after a change
  always_comb begin
    next_cur = (demand_i < limit_i) ? demand_i : limit_i;
  end
  always_ff @(posedge ref_clk_i) begin
    current_o <= next_cur;
  end
endmodule : motl_motor_model
`default_nettype wire

/* File: verif/tb_top.sv */
// bench: apb master, integer model of the heat accumulator
// assumes the limiter with a short control period
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import motl_pkg::*;
  localparam int CYC = 20;
  logic ref_clk_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, demand = 32'h07D0, prdata, limit, meas, r;
  logic pready, pslverr, active, tick;
  int n_mismatch = 0, tests_run = 0, seed = 32'hC4D2;
  int acc, lim, rated, peak, thr, m;
  motl_limiter #(.CTRL_CYC(CYC)) u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .measured_current_i(meas), .imposed_current_limit_o(limit), .limiter_active_o(active), .period_tick_o(tick));
  motl_motor_model u_motor (.ref_clk_i(ref_clk_i), .demand_i(demand), .limit_i(limit), .current_o(meas));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  // ----------------
  // bus and checks
  // ----------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_i);
    pen <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  // watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge ref_clk_i);
    n_mismatch++;
    test_done();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (int a = 0; a <= 36; a += 4) rd(a[7:0], 32'h0);
    m = $random(seed) & 32'h0000FFFF;
    apb(1'b1, OFS_MAX_MOTOR_CUR, m);
    rd(OFS_MAX_MOTOR_CUR, m);
    chk(limit, m);
    apb(1'b1, OFS_MAX_MOTOR_CUR, 32'h2710);
    apb(1'b1, OFS_RATED_CUR, 32'h07D0);
    apb(1'b1, OFS_PEAK_PERMILLE, 32'h03E8);
    apb(1'b1, OFS_PEAK_DURATION, 32'h64);
    apb(1'b1, OFS_SUBMODE, 32'h1);
    rd(OFS_STATUS, 32'h0);
    apb(1'b1, OFS_PEAK_PERMILLE, 32'h07D0);
    apb(1'b1, OFS_PEAK_DURATION, 32'h0);
    rd(OFS_STATUS, 32'h0);
    apb(1'b1, OFS_SUBMODE, 32'h0);
    apb(1'b1, OFS_PEAK_DURATION, 32'h64);
    rd(OFS_STATUS, 32'h0);
    apb(1'b1, OFS_SUBMODE, 32'h1);
    rd(OFS_STATUS, 32'h1);
    chk({31'h0, active}, 32'h1);
    // threshold is refreshed once per control period: let two pass
    repeat (2 * CYC) @(posedge ref_clk_i);
    rd(OFS_THRESHOLD, 32'h4B0);
    chk(limit, 32'h0FA0);
    apb(1'b1, OFS_MAX_MOTOR_CUR, 32'h0BB8);
    repeat (2 * CYC) @(posedge ref_clk_i);
    rd(OFS_THRESHOLD, 32'h1F4);
    chk(limit, 32'h0BB8);
    apb(1'b1, OFS_MAX_MOTOR_CUR, 32'h2710);
    repeat (2 * CYC) @(posedge ref_clk_i);
    rated = 2000;
    peak = 4000;
    thr = (peak * peak - rated * rated) * 100 / 1000000;
    acc = 0;
    lim = peak;
    @(posedge ref_clk_i iff tick === 1'b1);
    demand <= 32'h1388;
    // heat rises to the limit, clamps, then cools to zero
    for (int i = 0; i < 700; i++) begin
      if (i == 140) demand <= 32'h03E8;
      @(posedge ref_clk_i iff tick === 1'b1);
      m = (demand < lim) ? demand : lim;
      acc = acc + (m * m - rated * rated) / 1000000;
      if (acc < 0) acc = 0;
      lim = (acc >= thr) ? rated : peak;
      repeat (8) @(posedge ref_clk_i);
      rd(OFS_ACCUM, acc);
      chk(limit, lim);
    end
    apb(1'b1, OFS_SUBMODE, 32'h0);
    rd(OFS_STATUS, 32'h0);
    chk({31'h0, active}, 32'h0);
    rd(OFS_LIMIT, 32'h2710);
    test_done();
  end
endmodule : tb_top
bind motl_limiter motl_limiter_assertions #(.CTRL_CYC(CTRL_CYC)) u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .measured_current_i(measured_current_i),
  .imposed_current_limit_o(imposed_current_limit_o), .limiter_active_o(limiter_active_o),
  .period_tick_o(period_tick_o));
`default_nettype wire
